// File: hw/rec_formatter.sv
// Purpose: builds ethernet capture records as a byte stream
// Assumes: frame bytes arrive with valid/ready, count given by frame_len_i, no last marker
// Notes: record metadata is taken with start_i while idle
//
// Decided for this implementation: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module rec_formatter #(
  parameter int EXT_MAX = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // record request
  input wire logic start_i,
  input wire logic [63:0] tstamp_i,
  input wire logic [7:0] flags_i,
  input wire logic [15:0] wire_len_i,
  input wire logic [15:0] frame_len_i,
  input wire logic [15:0] color_i,
  input wire logic [2:0] ext_count_i,
  input wire logic [EXT_MAX*64-1:0] ext_data_i,
  input wire logic drop_i,
  output logic busy_o,
  // frame bytes in
  input wire logic frame_valid_i,
  input wire logic [7:0] frame_data_i,
  output logic frame_ready_o,
  // record bytes out
  output logic out_valid_o,
  output logic [7:0] out_data_o,
  output logic out_last_o,
  input wire logic out_ready_i
);
  typedef enum {IDLE, HDR, EXT, OFS, PAD, PAY} phase_e;
  phase_e st_r, st_nxt; // emission phase
  logic [2:0] ctrl_r, ctrl_nxt; // colour select, class select, ext enable
  logic [31:0] recs_r, recs_nxt; // records started
  logic [31:0] drops_r, drops_nxt; // drops seen
  logic [31:0] dat_r, dat_nxt;
  logic ack_r, ack_nxt;
  logic [127:0] hdr_r, hdr_nxt; // fixed header, byte 0 at msb
  logic [EXT_MAX*64-1:0] ext_r, ext_nxt; // extension headers
  logic [2:0] ext_n_r, ext_n_nxt; // extension headers left
  logic [15:0] idx_r, idx_nxt; // byte index within phase
  logic [15:0] pay_r, pay_nxt; // payload bytes
  logic v_r, v_nxt;
  logic [7:0] d_r, d_nxt;
  logic l_r, l_nxt;
  logic busy_r, busy_nxt;
  logic [2:0] ext_use; // extension headers after enable
  logic [6:0] code; // selected type code
  logic [15:0] rlen; // whole record length
  logic [15:0] loss_or_color; // field after length
  logic slot_free; // output register may load
  rec_loss_if lif();
  rec_loss_counter u_loss (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .lif(lif.counter)
  );
  assign lif.drop = drop_i;
  assign lif.take = (st_r == IDLE) && start_i;
  // ==========================================================
  // byte pick from a wide word, msb first
  function automatic logic [7:0] pick(input logic [127:0] w, input logic [15:0] i);
    pick = w[8'(127 - 8 * i[3:0]) -: 8];
  endfunction
  // ==========================================================
  // header field selection
  always_comb begin
    ext_use = ctrl_r[rec_fmt_pkg::CTRL_EXT_EN] ? ext_count_i : 3'h0;
    if (ctrl_r[rec_fmt_pkg::CTRL_CLASS_SEL]) begin
      code = rec_fmt_pkg::CLASSIFIED_ETHERNET_CODE; // see RULE5
    end else if (ctrl_r[rec_fmt_pkg::CTRL_COLOR_SEL]) begin
      code = rec_fmt_pkg::COLORED_ETHERNET_CODE; // see RULE5
    end else begin
      code = rec_fmt_pkg::ETHERNET_RECORD_CODE; // see RULE2 see RULE3 see RULE4
    end
    loss_or_color = (code == rec_fmt_pkg::ETHERNET_RECORD_CODE) ? lif.count
                                                                : color_i; // see RULE10
    // see RULE8 see RULE9 see RULE11
    rlen = rec_fmt_pkg::FIXED_HDR_BYTES + 16'(ext_use) * rec_fmt_pkg::EXT_HDR_BYTES
         + rec_fmt_pkg::OFFSET_PAD_BYTES + frame_len_i;
  end
  assign slot_free = !v_r || out_ready_i;
  // ==========================================================
  // record sequencer, next state
  always_comb begin
    st_nxt = st_r;
    hdr_nxt = hdr_r;
    ext_nxt = ext_r;
    ext_n_nxt = ext_n_r;
    idx_nxt = idx_r;
    pay_nxt = pay_r;
    v_nxt = v_r && !out_ready_i;
    d_nxt = d_r;
    l_nxt = l_r && !out_ready_i;
    busy_nxt = busy_r;
    frame_ready_o = 1'b0;
    case (st_r)
      IDLE: begin
        if (start_i) begin
          // see RULE1
          hdr_nxt = {tstamp_i, ext_use != 3'h0, code, flags_i, rlen, loss_or_color,
                     wire_len_i};
          ext_nxt = ext_data_i;
          ext_n_nxt = ext_use;
          pay_nxt = frame_len_i;
          idx_nxt = 16'h0000;
          busy_nxt = 1'b1;
          st_nxt = HDR;
        end
      end
      HDR: begin
        if (slot_free) begin
          v_nxt = 1'b1;
          d_nxt = pick(hdr_r, idx_r); // see RULE12
          l_nxt = 1'b0;
          idx_nxt = idx_r + 16'h0001;
          if (idx_r == rec_fmt_pkg::FIXED_HDR_BYTES - 16'h0001) begin
            idx_nxt = 16'h0000;
            st_nxt = (ext_n_r != 3'h0) ? EXT : OFS;
          end
        end
      end
      EXT: begin
        if (slot_free) begin
          v_nxt = 1'b1;
          // see RULE11: continue bit forced from remaining count
          d_nxt = ext_r[EXT_MAX*64-1 -: 8];
          if (idx_r == 16'h0000) begin
            d_nxt[rec_fmt_pkg::TYPE_EXT_BIT] = ext_n_r != 3'h1;
          end
          ext_nxt = {ext_r[EXT_MAX*64-9:0], 8'h00};
          idx_nxt = idx_r + 16'h0001;
          if (idx_r == rec_fmt_pkg::EXT_HDR_BYTES - 16'h0001) begin
            idx_nxt = 16'h0000;
            ext_n_nxt = ext_n_r - 3'h1;
            st_nxt = (ext_n_r == 3'h1) ? OFS : EXT;
          end
        end
      end
      OFS: begin
        if (slot_free) begin
          v_nxt = 1'b1;
          d_nxt = rec_fmt_pkg::OFFSET_BYTE_VAL; // see RULE6
          st_nxt = PAD;
        end
      end
      PAD: begin
        if (slot_free) begin
          v_nxt = 1'b1;
          d_nxt = rec_fmt_pkg::PAD_BYTE_VAL; // see RULE7
          l_nxt = pay_r == 16'h0000;
          st_nxt = (pay_r == 16'h0000) ? IDLE : PAY;
          busy_nxt = pay_r != 16'h0000;
        end
      end
      PAY: begin
        frame_ready_o = slot_free;
        if (slot_free && frame_valid_i) begin
          v_nxt = 1'b1;
          d_nxt = frame_data_i; // see RULE7 see RULE8
          pay_nxt = pay_r - 16'h0001;
          l_nxt = pay_r == 16'h0001;
          if (pay_r == 16'h0001) begin
            st_nxt = IDLE;
            busy_nxt = 1'b0;
          end
        end
      end
      default: st_nxt = IDLE;
    endcase
  end
  // ==========================================================
  // register bus, next values
  always_comb begin
    ctrl_nxt = ctrl_r;
    recs_nxt = recs_r + ((st_r == IDLE && start_i) ? 32'h0000_0001 : 32'h0000_0000);
    drops_nxt = drops_r + (drop_i ? 32'h0000_0001 : 32'h0000_0000);
    ack_nxt = cyc_i && stb_i && !ack_r;
    dat_nxt = 32'h0000_0000;
    // write lands at the edge where the master sees ack, not one edge early
    if (cyc_i && stb_i && ack_r && we_i && sel_i[0]
        && adr_i == rec_fmt_pkg::CTRL_ADDR) begin
      ctrl_nxt = dat_i[2:0];
    end
    if (cyc_i && stb_i && !ack_r) begin
      case (adr_i)
        rec_fmt_pkg::CTRL_ADDR: begin
          dat_nxt = {29'h0000_0000, ctrl_r};
        end
        rec_fmt_pkg::STATUS_ADDR: dat_nxt = {16'h0000, lif.count};
        rec_fmt_pkg::RECORDS_ADDR: dat_nxt = recs_r;
        rec_fmt_pkg::DROPS_ADDR: dat_nxt = drops_r;
        default: dat_nxt = 32'h0000_0000;
      endcase
    end
  end
  // ==========================================================
  // all registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= IDLE;
      hdr_r <= '0;
      ext_r <= '0;
      ext_n_r <= 3'h0;
      idx_r <= 16'h0000;
      pay_r <= 16'h0000;
      v_r <= 1'b0;
      d_r <= 8'h00;
      l_r <= 1'b0;
      busy_r <= 1'b0;
      ctrl_r <= rec_fmt_pkg::CTRL_RESET;
      recs_r <= 32'h0000_0000;
      drops_r <= 32'h0000_0000;
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else if (ce_i) begin
      st_r <= st_nxt;
      hdr_r <= hdr_nxt;
      ext_r <= ext_nxt;
      ext_n_r <= ext_n_nxt;
      idx_r <= idx_nxt;
      pay_r <= pay_nxt;
      v_r <= v_nxt;
      d_r <= d_nxt;
      l_r <= l_nxt;
      busy_r <= busy_nxt;
      ctrl_r <= ctrl_nxt;
      recs_r <= recs_nxt;
      drops_r <= drops_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end
  assign out_valid_o = v_r;
  assign out_data_o = d_r;
  assign out_last_o = l_r;
  assign busy_o = busy_r;
  assign ack_o = ack_r;
  assign dat_o = dat_r;
endmodule // rec_formatter

// File: hw/rec_fmt_pkg.sv
// Purpose: constants for the capture record formatter
// Assumes: byte-wide output stream, 16-byte fixed header
// Notes: header byte order is timestamp, type, flags, length, loss, wire length
//
// Contract
// RULE1: type bit 7 set when extension headers follow
// RULE2: ethernet record carries type code 2
// RULE3: type codes follow the fixed enumeration
// RULE4: codes 32 to 47 never used here
// RULE5: types 11 and 16 carry colour instead
// RULE6: offset byte present, contents meaningless
// RULE7: pad byte then frame, aligns layer 3
// RULE8: payload equals length minus headers minus two
// RULE9: length field equals total record bytes sent
// RULE10: loss field counts packets dropped since last
// RULE11: each extension header is eight bytes
// RULE12: contiguous stream in fixed field order
package rec_fmt_pkg;
  // ==========================================================
  // record type codes
  localparam logic [6:0] OLD_STYLE_RECORD_CODE = 7'h00;
  localparam logic [6:0] HDLC_POS_CODE = 7'h01;
  localparam logic [6:0] ETHERNET_RECORD_CODE = 7'h02;
  localparam logic [6:0] ATM_CELL_CODE = 7'h03;
  localparam logic [6:0] AAL5_CODE = 7'h04;
  localparam logic [6:0] COLORED_ETHERNET_CODE = 7'h0b;
  localparam logic [6:0] CLASSIFIED_ETHERNET_CODE = 7'h10;
  localparam logic [6:0] IPV4_RECORD_CODE = 7'h16;
  localparam logic [6:0] IPV6_RECORD_CODE = 7'h17;
  localparam logic [6:0] RAW_LINK_CODE = 7'h18;
  localparam logic [6:0] PAD_RECORD_CODE = 7'h30;
  localparam logic [6:0] RESERVED_LO_CODE = 7'h20;
  localparam logic [6:0] RESERVED_HI_CODE = 7'h2f;
  // ==========================================================
  // layout
  localparam int TYPE_EXT_BIT = 7;
  localparam logic [15:0] FIXED_HDR_BYTES = 16'h0010;
  localparam logic [15:0] EXT_HDR_BYTES = 16'h0008;
  localparam logic [15:0] OFFSET_PAD_BYTES = 16'h0002;
  localparam logic [4:0] TYPE_BYTE_IDX = 5'h08;
  localparam logic [7:0] OFFSET_BYTE_VAL = 8'h00;
  localparam logic [7:0] PAD_BYTE_VAL = 8'h00;
  // ==========================================================
  // register map, word addresses in bytes
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] RECORDS_ADDR = 8'h08;
  localparam logic [7:0] DROPS_ADDR = 8'h0c;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam int CTRL_COLOR_SEL = 0;
  localparam int CTRL_CLASS_SEL = 1;
  localparam int CTRL_EXT_EN = 2;
endpackage

// File: hw/rec_loss_if.sv
// Purpose: carries drop events and loss snapshot between modules
// Assumes: single clock
// Notes: take pulses when the record header latches the count
`timescale 1ns/1ps
interface rec_loss_if;
  logic drop; // one packet lost upstream
  logic take; // header latched the count
  logic [15:0] count; // drops since last take
  modport counter(input drop, input take, output count);
  modport user(output drop, output take, input count);
endinterface

// File: hw/rec_loss_counter.sv
// Purpose: counts dropped packets between records
// Assumes: drop and take are same-clock pulses
// Notes: a drop in the take cycle lands in the next record
`timescale 1ns/1ps
module rec_loss_counter (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  rec_loss_if.counter lif
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  // ==========================================================
  // next count, saturating at all ones
  always_comb begin
    if (lif.take) begin
      cnt_nxt = {15'h0000, lif.drop}; // see RULE10
    end else if (lif.drop && cnt_r != 16'hffff) begin
      cnt_nxt = cnt_r + 16'h0001; // see RULE10
    end else begin
      cnt_nxt = cnt_r;
    end
  end
  // register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 16'h0000;
    end else if (ce_i) begin
      cnt_r <= cnt_nxt;
    end
  end
  assign lif.count = cnt_r;
endmodule // rec_loss_counter

// File: verification/rec_sink_model.sv
// Purpose: host stream buffer model taking record bytes
// Assumes: one byte per accepted valid/ready beat
// Notes: slow_i makes ready toggle every cycle
`timescale 1ns/1ps
module rec_sink_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic valid_i,
  input wire logic [7:0] data_i,
  input wire logic last_i,
  output logic ready_o
);
  logic [7:0] q[$]; // received bytes, bench pops them
  int recs; // records ended by a last byte
  // accept bytes, count records, pace ready
  always @(posedge clk_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
      recs = 0;
    end else begin
      if (valid_i && ready_o) begin
        q.push_back(data_i); // offset byte kept but never judged
        if (last_i) recs++;
      end
      ready_o <= slow_i ? ~ready_o : 1'b1;
    end
  end
endmodule // rec_sink_model

// File: verification/rec_formatter_props.sv
// Purpose: port checker for rec_formatter
// Assumes: ce_i held high
// Notes: idx_r counts accepted record bytes
`timescale 1ns/1ps
module rec_formatter_props #(
  parameter int EXT_MAX = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic start_i,
  input wire logic busy_o,
  input wire logic frame_ready_o,
  input wire logic out_valid_o,
  input wire logic [7:0] out_data_o,
  input wire logic out_last_o,
  input wire logic out_ready_i
);
  logic [15:0] idx_r; // byte index within record
  logic [15:0] idx_nxt;
  logic ty; // type byte on the output
  assign ty = out_valid_o && idx_r == 16'h0008;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // step index on each accepted byte
  always_comb begin
    idx_nxt = idx_r;
    if (out_valid_o && out_ready_i) begin
      idx_nxt = out_last_o ? 16'h0000 : idx_r + 16'h0001;
    end
  end
  always_ff @(posedge clk_i) begin
    idx_r <= rst_i ? 16'h0000 : idx_nxt;
  end
  property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("bus request not acked");
  property p_ack_once; ack_o |=> !ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  property p_dat_idle; !ack_o |-> dat_o == 32'h0000_0000; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_hold; out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o)
    && $stable(out_last_o); endproperty
  a_hold: assert property (p_hold) else $error("byte dropped in stall");
  property p_start; start_i && !busy_o |=> busy_o ##1 out_valid_o; endproperty
  a_start: assert property (p_start) else $error("record start late");
  property p_type; ty |-> out_data_o[6:0] <= 7'h18 || out_data_o[6:0] == 7'h30; endproperty
  a_type: assert property (p_type) else $error("type code undefined");
  property p_rsvd; ty |-> !(out_data_o[6:0] inside {[7'h20:7'h2f]}); endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved type code");
  property p_eth; ty |-> out_data_o[6:0] inside {7'h02, 7'h0b, 7'h10}; endproperty
  a_eth: assert property (p_eth) else $error("not an ethernet code");
  property p_rel; $fell(rst_i) |-> !out_valid_o && !busy_o && !ack_o; endproperty
  a_rel: assert property (p_rel) else $error("outputs active after reset");
  c_ack: cover property (ack_o);
  c_stall: cover property (out_valid_o && !out_ready_i);
  c_last: cover property (out_valid_o && out_ready_i && out_last_o);
endmodule // rec_formatter_props
bind rec_formatter rec_formatter_props #(.EXT_MAX(EXT_MAX)) u_props (.clk_i, .rst_i, .cyc_i,
  .stb_i, .dat_o, .ack_o, .start_i, .busy_o, .frame_ready_o, .out_valid_o, .out_data_o,
  .out_last_o, .out_ready_i);

// File: verification/eth_capture_record_formatter_test.sv
// Purpose: bench for the capture record formatter
// Assumes: ce_i held high, one clock
// Notes: record bytes are gathered by the sink model
`timescale 1ns/1ps
module eth_capture_record_formatter_test;
  localparam logic [63:0] TS = 64'h0123_4567_89ab_cdef; // timestamp pattern
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, start_i = 0, drop_i = 0;
  logic frame_valid_i = 0, slow = 0, busy_o, frame_ready_o, out_valid_o, out_last_o;
  logic ack_o, rdy;
  logic [7:0] adr_i = 0, frame_data_i = 0, out_data_o;
  logic [31:0] dat_i = 0, dat_o, rd;
  logic [15:0] frame_len_i = 0, wire_len_i = 0, color_i = 16'hc0de;
  logic [2:0] ext_count_i = 0;
  int fail_count = 0, comparisons = 0;
  rec_formatter #(.EXT_MAX(4)) dut (.clk_i, .rst_i, .ce_i(1'b1), .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i(4'hf), .dat_i, .dat_o, .ack_o, .start_i, .tstamp_i(TS), .flags_i(8'ha5),
    .wire_len_i, .frame_len_i, .color_i, .ext_count_i, .ext_data_i({32{8'h5a}}), .drop_i,
    .busy_o, .frame_valid_i, .frame_data_i, .frame_ready_o, .out_valid_o, .out_data_o,
    .out_last_o, .out_ready_i(rdy));
  rec_sink_model snk (.clk_i, .rst_i, .slow_i(slow), .valid_i(out_valid_o),
    .data_i(out_data_o), .last_i(out_last_o), .ready_o(rdy));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    if (fail_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tmo(input bit bad);
    if (bad) begin
      $display("ERROR %0t wait timed out", $time);
      fail_count++;
      report_and_stop();
    end
  endtask
  // one classic wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    for (k = 0; k < 200 && !ack_o; k++) @(posedge clk_i);
    tmo(k == 200);
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
  endtask
  function automatic logic [15:0] pop16();
    logic [7:0] h;
    h = snk.q.pop_front();
    return {h, snk.q.pop_front()};
  endfunction
  // one record: ctrl value, ext count, payload length, drops before start
  task automatic rec(input logic [2:0] ctl, input int ne, input int len, input int nd);
    logic [6:0] code;
    int n, i, k, h, r0;
    code = ctl[1] ? 7'h10 : ctl[0] ? 7'h0b : 7'h02;
    n = ctl[2] ? ne : 0;
    wb(1, 8'h00, {29'h0, ctl});
    repeat (nd) begin
      @(posedge clk_i);
      drop_i <= 1;
      @(posedge clk_i);
      drop_i <= 0;
    end
    wb(0, 8'h04, 0);
    chk(rd, nd);
    r0 = snk.recs;
    @(posedge clk_i);
    start_i <= 1;
    frame_len_i <= 16'(len);
    wire_len_i <= 16'(len + 4);
    ext_count_i <= 3'(ne);
    @(posedge clk_i);
    start_i <= 0;
    i = 0;
    for (k = 0; k < 2000 && i < len; k++) begin
      frame_valid_i <= 1;
      frame_data_i <= 8'(i);
      @(posedge clk_i);
      if (frame_ready_o) i++;
    end
    frame_valid_i <= 0;
    tmo(i < len);
    for (k = 0; k < 2000 && snk.recs == r0; k++) @(posedge clk_i);
    tmo(snk.recs == r0);
    for (k = 0; k < 8; k++) chk(snk.q.pop_front(), TS[63-8*k -: 8]);
    chk(snk.q.pop_front(), {n != 0, code});
    chk(snk.q.pop_front(), 8'ha5);
    chk(pop16(), 18 + 8 * n + len);
    chk(pop16(), code == 7'h02 ? 16'(nd) : color_i);
    chk(pop16(), len + 4);
    for (h = 0; h < n * 8; h++) chk(snk.q.pop_front(), h < n * 8 - 8 && h % 8 == 0 ?
      8'hda : 8'h5a);
    void'(snk.q.pop_front()); // offset contents disregarded
    chk(snk.q.pop_front(), 8'h00);
    for (i = 0; i < len; i++) chk(snk.q.pop_front(), 8'(i));
    chk(snk.q.size(), 0);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 8'h00, 0);
    chk(rd, 0);
    wb(1, 8'h08, 32'h0000_ffff);
    wb(0, 8'h08, 0);
    chk(rd, 0);
    wb(0, 8'h40, 0);
    chk(rd, 0);
    rec(3'h0, 0, 5, 3);
    rec(3'h5, 2, 8, 1);
    slow <= 1;
    rec(3'h3, 1, 1, 0);
    rec(3'h4, 4, 4, 0);
    wb(0, 8'h08, 0);
    chk(rd, 4);
    wb(0, 8'h0c, 0);
    chk(rd, 4);
    wb(0, 8'h00, 0);
    chk(rd, 4);
    report_and_stop();
  end
endmodule // eth_capture_record_formatter_test
